// ### hw/mcf_regmap.sv
/*
 * Per-channel register exchange: output group, two 32-entry response
 * FIFOs per channel, fill level reporting, session and claim checks,
 * and an 8-entry ingress FIFO for responses.
 * Assumes a frame layer on mclk that splits requests into word accesses
 * and an identification engine on mclk that delivers responses.
 */
`timescale 1ns/1ps
`include "mcf_defs.svh"

module mcf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = cnt_r != DEPTH[AW:0];
    assign outValid = cnt_r != '0;
    assign outData = mem[rp_r];
    assign count = cnt_r;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= inData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || flush) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : mcf_fifo

// Summary of operation
// RULE1: Requests accepted only on port 502
// RULE2: Read, write, read/write functions supported
// RULE3: ID 1 writes output, reads primary
// RULE4: ID 2 reads monitor FIFO only
// RULE5: One master per channel and ID
// RULE6: At most six sessions at once
// RULE7: Three channel areas at 1000-word steps
// RULE8: Output, primary and monitor groups per channel
// RULE9: Output words: delete, length, command, parameters
// RULE10: Length word holds (N+1) div/mod 256
// RULE11: Delete bit rising edge flushes channel FIFOs
// RULE12: Input words: level, length, echo, status, data
// RULE13: Two 32-entry FIFOs per channel
// RULE14: Finished group read pops one element
// RULE15: First input word reports fill percentage
// RULE16: Level 0 empty, 1-100 data, 101 lost
// RULE17: Full FIFO drops new responses
// RULE18: Master polls to keep level under 15%
// RULE19: Errors answered with exception code
// RULE20: Master writes command then reads result
// RULE21: Status 05 means no carrier present
// RULE22: Telegram codes match socket interface
// RULE23: Master inverts toggle to repeat
// RULE24: Empty FIFO reads return zero
// RULE25: Interim confirmation carries status FFh
// RULE26: Lost code holds until emptied or flushed
module mcf_regmap
    import mcf_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sessOpen,
    input wire logic sessClose,
    input wire logic [2:0] sessId,
    output logic sessAckValid,
    output logic sessAckOk,
    input wire logic reqValid,
    input wire mcf_req_t reqIn,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic [7:0] rspExc,
    output logic cmdValid,
    output mcf_cmd_t cmdOut,
    input wire logic ingValid,
    output logic ingReady,
    input wire mcf_ing_t ingData
);
    function automatic logic [1:0] chanOf(input logic [15:0] a);
        if (a < `MCF_BASE_CH1) begin
            chanOf = 2'd0;
        end else if (a < `MCF_BASE_CH2) begin
            chanOf = 2'd1;
        end else if (a < `MCF_BASE_END) begin
            chanOf = 2'd2;
        end else begin
            chanOf = 2'd3;
        end
    endfunction : chanOf

    function automatic logic [15:0] baseOf(input logic [1:0] c);
        case (c)
            2'd1: baseOf = `MCF_BASE_CH1;
            2'd2: baseOf = `MCF_BASE_CH2;
            default: baseOf = `MCF_BASE_CH0;
        endcase
    endfunction : baseOf

    function automatic logic [3:0] popCount(input logic [7:0] v);
        popCount = 4'd0;
        for (int i = 0; i < 8; i++) begin
            popCount = popCount + {3'd0, v[i]};
        end
    endfunction : popCount

    function automatic logic [7:0] utilOf(input logic [5:0] n, input logic lost);
        logic [11:0] pct;
        pct = (12'({6'd0, n}) * `MCF_PCT_FULL + 12'd31) >> 5;
        if (lost && n != 6'd0) begin
            utilOf = `MCF_UTIL_LOST; // RULE16
        end else begin
            utilOf = pct[7:0]; // RULE15
        end
    endfunction : utilOf

    // Sessions and claims
    logic [7:0] sessAct_r;
    logic [7:0] sessAct_nxt;
    logic sessAckValid_r;
    logic sessAckOk_r;
    logic [1:0] claimV_r [MCF_CHANS];
    logic [2:0] claimS_r [MCF_CHANS][2];

    // Request decode
    wire mcf_req_t rq = reqIn;
    wire [1:0] chRaw = chanOf(rq.addr); // RULE7
    wire chOk = chRaw != 2'd3;
    wire [1:0] ch = chOk ? chRaw : 2'd0;
    wire [15:0] off = rq.addr - baseOf(ch);
    wire isCtl = rq.unit == `MCF_ID_CTL;
    wire isMon = rq.unit == `MCF_ID_MON;
    wire grpOut = rq.write && isCtl; // RULE3 RULE8
    wire grpIn = !rq.write && isCtl; // RULE3 RULE8
    wire grpMon = !rq.write && isMon; // RULE4 RULE8
    wire fnRd = rq.func == `MCF_FN_READ;
    wire fnWr = rq.func == `MCF_FN_WRITE;
    wire fnRw = rq.func == `MCF_FN_RDWR;
    wire fnOk = fnRw || (fnRd && !rq.write) || (fnWr && rq.write); // RULE2
    wire portOk = rq.port == `MCF_TCP_PORT; // RULE1
    wire sessOk = sessAct_r[rq.sess]; // RULE6
    wire idSel = isMon;
    wire claimFree = !claimV_r[ch][idSel];
    wire claimMine = claimS_r[ch][idSel] == rq.sess;
    wire claimOk = claimFree || claimMine; // RULE5
    wire offOk = rq.write ? (off <= `MCF_OUT_LAST) : (off <= `MCF_IN_LAST);
    wire permOk = grpOut || grpIn || grpMon; // RULE4
    wire [7:0] excCode = !portOk ? `MCF_EXC_GATEWAY :
                         !fnOk ? `MCF_EXC_FUNC :
                         !(chOk && offOk) ? `MCF_EXC_ADDR :
                         !(sessOk && permOk && claimOk) ? `MCF_EXC_DENIED :
                         `MCF_EXC_NONE; // RULE19
    wire accept = reqValid && excCode == `MCF_EXC_NONE;
    wire doWrite = accept && grpOut;
    wire doRead = accept && !rq.write;

    // Output group
    logic [15:0] outCtl_r [MCF_CHANS];
    logic [15:0] outLen_r [MCF_CHANS];
    logic [15:0] outCmd_r [MCF_CHANS];
    logic [15:0] outP0_r [MCF_CHANS];
    logic [15:0] outP1_r [MCF_CHANS];
    logic cmdValid_r;
    mcf_cmd_t cmd_r;
    mcf_cmd_t cmd_nxt;
    wire delRise = doWrite && off == `MCF_OFF_CTL && rq.wdata[`MCF_DEL_BIT]
        && !outCtl_r[ch][`MCF_DEL_BIT]; // RULE11
    logic [MCF_CHANS-1:0] flushCh;

    // Ingress buffer; bus accesses take priority over draining it
    mcf_ing_t ingHead;
    logic ingHeadValid;
    wire drain = ingHeadValid && !reqValid;

    mcf_fifo #(.W($bits(mcf_ing_t)), .DEPTH(MCF_ING_DEPTH)) u_ing (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .flush(1'b0),
        .inValid(ingValid),
        .inReady(ingReady),
        .inData(ingData),
        .outValid(ingHeadValid),
        .outReady(drain),
        .outData(ingHead),
        .count()
    );

    // Response stores: index 0 primary, 1 monitor
    mcf_resp_t head [MCF_CHANS][2];
    logic [5:0] fill [MCF_CHANS][2];
    logic lost_r [MCF_CHANS][2];
    wire popLast = doRead && rq.last; // RULE14

    for (genvar c = 0; c < MCF_CHANS; c++) begin : g_ch
        assign flushCh[c] = delRise && ch == 2'(c);
        for (genvar k = 0; k < 2; k++) begin : g_kind
            logic inRdy;
            logic hv;
            wire put = drain && ingHead.ch == 2'(c);
            wire take = popLast && ch == 2'(c) && idSel == 1'(k);
            mcf_fifo #(.W($bits(mcf_resp_t)), .DEPTH(MCF_DEPTH)) u_store ( // RULE13
                .mclk(mclk),
                .sys_rst(sys_rst),
                .flush(flushCh[c]),
                .inValid(put),
                .inReady(inRdy),
                .inData(ingHead.resp),
                .outValid(hv),
                .outReady(take),
                .outData(head[c][k]),
                .count(fill[c][k])
            );
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    lost_r[c][k] <= 1'b0;
                end else if (put && !inRdy) begin
                    lost_r[c][k] <= 1'b1; // RULE17 RULE26
                end else if (flushCh[c] || !hv) begin
                    lost_r[c][k] <= 1'b0; // RULE26
                end
            end
        end
    end

    // Input group read mux
    wire mcf_resp_t hd = head[ch][idSel];
    wire [5:0] hFill = fill[ch][idSel];
    wire hEmpty = hFill == 6'd0;
    wire [15:0] rdWord = (off == `MCF_OFF_UTIL) ? {8'd0, utilOf(hFill, lost_r[ch][idSel])} :
                         hEmpty ? `MCF_RST_WORD : // RULE24
                         (off == `MCF_OFF_LEN) ? hd.len : // RULE10 RULE12
                         (off == `MCF_OFF_CMD) ? hd.cmdCtl : // RULE22
                         (off == `MCF_OFF_STAT) ? hd.statCnt : // RULE21 RULE25
                         (off == `MCF_OFF_D0) ? hd.data0 :
                         hd.data1; // RULE12
    logic rspValid_r;
    logic [15:0] rspData_r;
    logic [7:0] rspExc_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rspValid_r <= 1'b0;
            rspData_r <= `MCF_RST_WORD;
            rspExc_r <= `MCF_EXC_NONE;
        end else begin
            rspValid_r <= reqValid;
            rspData_r <= doRead ? rdWord : `MCF_RST_WORD;
            rspExc_r <= reqValid ? excCode : `MCF_EXC_NONE; // RULE19
        end
    end

    for (genvar c = 0; c < MCF_CHANS; c++) begin : g_out
        wire wr = doWrite && ch == 2'(c);
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                outCtl_r[c] <= `MCF_RST_WORD;
                outLen_r[c] <= `MCF_RST_WORD;
                outCmd_r[c] <= `MCF_RST_WORD;
                outP0_r[c] <= `MCF_RST_WORD;
                outP1_r[c] <= `MCF_RST_WORD;
            end else if (wr) begin
                outCtl_r[c] <= off == `MCF_OFF_CTL ? rq.wdata : outCtl_r[c]; // RULE9
                outLen_r[c] <= off == `MCF_OFF_LEN ? rq.wdata : outLen_r[c]; // RULE10
                outCmd_r[c] <= off == `MCF_OFF_CMD ? rq.wdata : outCmd_r[c]; // RULE9
                outP0_r[c] <= off == `MCF_OFF_P0 ? rq.wdata : outP0_r[c];
                outP1_r[c] <= off == `MCF_OFF_P1 ? rq.wdata : outP1_r[c];
            end
        end
    end

    // Command issue at the last word of a write, using that word too
    always_comb begin
        cmd_nxt.ch = ch;
        cmd_nxt.len = off == `MCF_OFF_LEN ? rq.wdata : outLen_r[ch];
        cmd_nxt.cmd = off == `MCF_OFF_CMD ? rq.wdata : outCmd_r[ch]; // RULE22
        cmd_nxt.p0 = off == `MCF_OFF_P0 ? rq.wdata : outP0_r[ch];
        cmd_nxt.p1 = off == `MCF_OFF_P1 ? rq.wdata : outP1_r[ch];
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmdValid_r <= 1'b0;
            cmd_r <= '0;
        end else begin
            cmdValid_r <= doWrite && rq.last; // RULE9
            cmd_r <= (doWrite && rq.last) ? cmd_nxt : cmd_r;
        end
    end

    // Sessions: open refused beyond six, close frees the claims held by the closing session
    wire openOk = sessOpen && !sessAct_r[sessId] && popCount(sessAct_r) < `MCF_MAX_SESS;
    always_comb begin
        sessAct_nxt = sessAct_r;
        if (sessClose) begin
            sessAct_nxt[sessId] = 1'b0;
        end
        if (openOk) begin
            sessAct_nxt[sessId] = 1'b1; // RULE6
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sessAct_r <= '0;
            sessAckValid_r <= 1'b0;
            sessAckOk_r <= 1'b0;
        end else begin
            sessAct_r <= sessAct_nxt;
            sessAckValid_r <= sessOpen;
            sessAckOk_r <= openOk;
        end
    end

    for (genvar c = 0; c < MCF_CHANS; c++) begin : g_claim
        for (genvar k = 0; k < 2; k++) begin : g_id
            wire grab = accept && ch == 2'(c) && idSel == 1'(k) && claimFree;
            wire drop = sessClose && claimS_r[c][k] == sessId;
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    claimV_r[c][k] <= 1'b0;
                    claimS_r[c][k] <= 3'd0;
                end else if (grab) begin
                    claimV_r[c][k] <= 1'b1; // RULE5
                    claimS_r[c][k] <= rq.sess;
                end else if (drop) begin
                    claimV_r[c][k] <= 1'b0;
                end
            end
        end
    end

    assign sessAckValid = sessAckValid_r;
    assign sessAckOk = sessAckOk_r;
    assign rspValid = rspValid_r;
    assign rspData = rspData_r;
    assign rspExc = rspExc_r;
    assign cmdValid = cmdValid_r;
    assign cmdOut = cmd_r;
endmodule : mcf_regmap

// ### pkg/mcf_defs.svh
/*
 * Constants of the per-channel register exchange: offsets, identifiers,
 * function and exception codes, status codes and reset values.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef MCF_DEFS_SVH
`define MCF_DEFS_SVH

// Listening port and unit identifiers
`define MCF_TCP_PORT 16'h01F6
`define MCF_ID_CTL 8'h01
`define MCF_ID_MON 8'h02

// Supported function codes
`define MCF_FN_READ 8'h03
`define MCF_FN_WRITE 8'h10
`define MCF_FN_RDWR 8'h17

// Exception codes
`define MCF_EXC_NONE 8'h00
`define MCF_EXC_FUNC 8'h01
`define MCF_EXC_ADDR 8'h02
`define MCF_EXC_DENIED 8'h04
`define MCF_EXC_GATEWAY 8'h0B

// Channel base offsets (decimal 0, 1000, 2000, 3000)
`define MCF_BASE_CH0 16'h0000
`define MCF_BASE_CH1 16'h03E8
`define MCF_BASE_CH2 16'h07D0
`define MCF_BASE_END 16'h0BB8

// Output group word offsets
`define MCF_OFF_CTL 16'h0000
`define MCF_OFF_LEN 16'h0001
`define MCF_OFF_CMD 16'h0002
`define MCF_OFF_P0 16'h0003
`define MCF_OFF_P1 16'h0004
`define MCF_OUT_LAST 16'h0004

// Input group word offsets
`define MCF_OFF_UTIL 16'h0000
`define MCF_OFF_STAT 16'h0003
`define MCF_OFF_D0 16'h0004
`define MCF_OFF_D1 16'h0005
`define MCF_IN_LAST 16'h0005

// Field positions
`define MCF_DEL_BIT 0

// Utilisation codes and limits
`define MCF_UTIL_LOST 8'h65
`define MCF_PCT_FULL 12'h064
`define MCF_MAX_SESS 4'h6

// Status codes carried in responses
`define MCF_ST_NO_CARRIER 8'h05
`define MCF_ST_BUSY 8'hFF

// Reset values
`define MCF_RST_WORD 16'h0000

`endif

// ### pkg/mcf_pkg.sv
/*
 * Types of the per-channel register exchange.
 * Assumes mcf_defs.svh sits on the include path.
 */
package mcf_pkg;
    `include "mcf_defs.svh"

    localparam int MCF_CHANS = 3;
    localparam int MCF_DEPTH = 32;
    localparam int MCF_ING_DEPTH = 8;

    // One stored response telegram
    typedef struct packed {
        logic [15:0] len;
        logic [15:0] cmdCtl;
        logic [15:0] statCnt;
        logic [15:0] data0;
        logic [15:0] data1;
    } mcf_resp_t;

    // Response as it enters the block
    typedef struct packed {
        logic [1:0] ch;
        mcf_resp_t resp;
    } mcf_ing_t;

    // One register word access from the frame layer
    typedef struct packed {
        logic [15:0] port;
        logic [7:0] func;
        logic [7:0] unit;
        logic [2:0] sess;
        logic write;
        logic last;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mcf_req_t;

    // Command telegram handed to the identification engine
    typedef struct packed {
        logic [1:0] ch;
        logic [15:0] len;
        logic [15:0] cmd;
        logic [15:0] p0;
        logic [15:0] p1;
    } mcf_cmd_t;
endpackage : mcf_pkg

// ### bench/mcf_regmap_props.sv
/* Port checker of mcf_regmap.
   Assumes binding to mcf_regmap, clock mclk, synchronous reset sys_rst. */
`timescale 1ns/1ps
`include "mcf_defs.svh"
module mcf_regmap_props
    import mcf_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sessOpen,
    input wire logic sessClose,
    input wire logic [2:0] sessId,
    input wire logic sessAckValid,
    input wire logic sessAckOk,
    input wire logic reqValid,
    input wire mcf_req_t reqIn,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic [7:0] rspExc,
    input wire logic cmdValid,
    input wire mcf_cmd_t cmdOut,
    input wire logic ingValid,
    input wire logic ingReady,
    input wire mcf_ing_t ingData
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire portOk = reqIn.port == `MCF_TCP_PORT;
    wire fnOk = (reqIn.func == `MCF_FN_READ && !reqIn.write)
        || (reqIn.func == `MCF_FN_WRITE && reqIn.write) || reqIn.func == `MCF_FN_RDWR;
    wire good = reqValid && portOk && fnOk;

    a_rsp_follows_req: assert property (reqValid |=> rspValid)
        else $error("no answer one cycle after a request");
    a_no_stray_rsp: assert property (!reqValid |=> !rspValid)
        else $error("answer without a request");
    a_wrong_port: assert property (reqValid && !portOk |=>
        rspExc == `MCF_EXC_GATEWAY && rspData == 16'h0000)
        else $error("request on a foreign port not refused");
    a_bad_function: assert property (reqValid && portOk && !fnOk |=>
        rspExc == `MCF_EXC_FUNC)
        else $error("unsupported function not refused");
    a_bad_address: assert property (good && reqIn.addr >= `MCF_BASE_END |=>
        rspExc == `MCF_EXC_ADDR)
        else $error("address beyond the channel areas not refused");
    a_monitor_no_write: assert property (good && reqIn.write
        && reqIn.unit == `MCF_ID_MON && reqIn.addr < 16'h0005 |=> rspExc == `MCF_EXC_DENIED)
        else $error("monitor write not denied");
    a_ack_after_open: assert property (sessOpen |=> sessAckValid)
        else $error("session open not acknowledged");
    a_no_stray_ack: assert property (!sessOpen |=> !sessAckValid)
        else $error("acknowledge without an open");
    a_cmd_needs_last: assert property (cmdValid |->
        $past(reqValid && reqIn.write && reqIn.last))
        else $error("command issued without a final write");
    a_util_code: assert property (reqValid && !reqIn.write
        && reqIn.addr == `MCF_BASE_CH1 |=> rspExc != 8'h00 || rspData <= 16'h0065)
        else $error("fill level out of its code range");
    a_refused_zero: assert property (rspValid && rspExc != 8'h00 |->
        rspData == 16'h0000)
        else $error("refused access returned data");
    c_command: cover property (cmdValid);
    c_open_refused: cover property (sessAckValid && !sessAckOk);
    c_lost_code: cover property (rspValid && rspData == 16'h0065);
endmodule : mcf_regmap_props

bind mcf_regmap mcf_regmap_props mcf_regmap_props_i (.mclk, .sys_rst, .sessOpen,
    .sessClose, .sessId, .sessAckValid, .sessAckOk, .reqValid, .reqIn, .rspValid,
    .rspData, .rspExc, .cmdValid, .cmdOut, .ingValid, .ingReady, .ingData);

// ### bench/mcf_resp_src.sv
/* Response source at the ingress of mcf_regmap.
   Assumes clock mclk and the bench calling push. */
`timescale 1ns/1ps
module mcf_resp_src
    import mcf_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ingReady,
    output logic ingValid,
    output mcf_ing_t ingData
);
    mcf_ing_t q[$];
    // Offer held until taken at a rising edge, changed at the falling edge; released data inverted
    initial begin
        ingValid = 1'b0;
        ingData = '0;
        forever begin
            @(posedge mclk);
            if (sys_rst) begin
                q.delete();
            end else if (ingValid && ingReady) begin
                void'(q.pop_front());
            end
            @(negedge mclk);
            ingValid = q.size() > 0;
            ingData = ingValid ? q[0] : ~ingData;
        end
    end
    task automatic push(input logic [1:0] ch, input int n);
        for (int k = 0; k < n; k++) begin
            q.push_back({ch, 16'h0006, 16'h1002, 8'h05, 8'(k), 16'(k), 16'hA5A5 ^ 16'(k)});
        end
    endtask : push
endmodule : mcf_resp_src

// ### bench/mcf_regmap_bench.sv
/* Self-checking bench of mcf_regmap with a response source.
   Assumes mcf_pkg and mcf_defs.svh compiled beforehand. */
`timescale 1ns/1ps
`include "mcf_defs.svh"
module mcf_regmap_bench
    import mcf_pkg::*;
;
    logic mclk, sys_rst, sessOpen, sessClose, reqValid, gotCmd;
    logic sessAckValid, sessAckOk, rspValid, cmdValid, ingValid, ingReady;
    logic [2:0] sessId;
    logic [15:0] rspData;
    logic [7:0] rspExc;
    mcf_req_t reqIn;
    mcf_cmd_t cmdOut;
    mcf_ing_t ingData;
    int miscompares, total_checks, cycles;

    mcf_regmap mcf_regmap_i (.mclk, .sys_rst, .sessOpen, .sessClose, .sessId,
        .sessAckValid, .sessAckOk, .reqValid, .reqIn, .rspValid, .rspData, .rspExc,
        .cmdValid, .cmdOut, .ingValid, .ingReady, .ingData);
    mcf_resp_src mcf_resp_src_i (.mclk, .sys_rst, .ingReady, .ingValid, .ingData);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [15:0] port, input logic [7:0] fn, input logic [7:0] un,
        input logic [2:0] s, input logic wr, input logic lst, input logic [15:0] a,
        input logic [15:0] wd, input logic [15:0] expD, input logic [7:0] expE);
        @(negedge mclk);
        reqValid = 1'b1;
        reqIn = '{port, fn, un, s, wr, lst, a, wd};
        @(negedge mclk);
        reqValid = 1'b0;
        gotCmd = cmdValid;
        chk(16'(rspValid), 16'h0001);
        chk(rspData, expD);
        chk(16'(rspExc), 16'(expE));
    endtask : acc
    task automatic rd(input logic [7:0] un, input logic [2:0] s, input logic [15:0] a,
        input logic lst, input logic [15:0] expD);
        acc(`MCF_TCP_PORT, `MCF_FN_READ, un, s, 1'b0, lst, a, 16'h0000, expD, `MCF_EXC_NONE);
    endtask : rd
    task automatic wrw(input logic [15:0] a, input logic [15:0] wd, input logic lst);
        acc(`MCF_TCP_PORT, `MCF_FN_WRITE, `MCF_ID_CTL, 3'h0, 1'b1, lst, a, wd, 16'h0000, 8'h00);
    endtask : wrw
    task automatic ses(input logic [2:0] id, input logic ok);
        @(negedge mclk);
        sessOpen = 1'b1;
        sessId = id;
        @(negedge mclk);
        sessOpen = 1'b0;
        chk(16'(sessAckValid), 16'h0001);
        chk(16'(sessAckOk), 16'(ok));
    endtask : ses
    task automatic drain();
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 200 && ingValid; i++) @(negedge mclk);
        repeat (12) @(negedge mclk);
    endtask : drain

    task automatic t_sessions();
        for (int i = 0; i < 6; i++) ses(3'(i), 1'b1);
        ses(3'h6, 1'b0);
        ses(3'h0, 1'b0);
        @(negedge mclk);
        sessClose = 1'b1;
        sessId = 3'h5;
        @(negedge mclk);
        sessClose = 1'b0;
        ses(3'h5, 1'b1);
        $display("test sessions done");
    endtask : t_sessions
    task automatic t_refusals();
        acc(16'h01F7, 8'h03, 8'h01, 3'h0, 1'b0, 1'b0, 16'h03E8, 0, 0, 8'h0B);
        acc(`MCF_TCP_PORT, 8'h04, 8'h01, 3'h0, 1'b0, 1'b0, 16'h03E8, 0, 0, 8'h01);
        acc(`MCF_TCP_PORT, 8'h03, 8'h01, 3'h0, 1'b1, 1'b0, 16'h03E8, 0, 0, 8'h01);
        acc(`MCF_TCP_PORT, 8'h03, 8'h01, 3'h0, 1'b0, 1'b0, 16'h0BB8, 0, 0, 8'h02);
        acc(`MCF_TCP_PORT, 8'h03, 8'h01, 3'h0, 1'b0, 1'b0, 16'h03EE, 0, 0, 8'h02);
        acc(`MCF_TCP_PORT, 8'h10, 8'h02, 3'h1, 1'b1, 1'b0, 16'h0000, 1, 0, 8'h04);
        acc(`MCF_TCP_PORT, 8'h03, 8'h03, 3'h0, 1'b0, 1'b0, 16'h03E8, 0, 0, 8'h04);
        acc(`MCF_TCP_PORT, 8'h03, 8'h01, 3'h7, 1'b0, 1'b0, 16'h03E8, 0, 0, 8'h04);
        $display("test refusals done");
    endtask : t_refusals
    task automatic t_command();
        wrw(16'h07D1, 16'h0006, 1'b0);
        wrw(16'h07D3, 16'h3033, 1'b0);
        wrw(16'h07D4, 16'h5A5A, 1'b0);
        wrw(16'h07D2, 16'h1940, 1'b1);
        chk(16'(gotCmd), 16'h0001);
        chk(16'(cmdOut.ch), 16'h0002);
        chk(cmdOut.len, 16'h0006);
        chk(cmdOut.cmd, 16'h1940);
        chk(cmdOut.p0, 16'h3033);
        chk(cmdOut.p1, 16'h5A5A);
        acc(`MCF_TCP_PORT, 8'h17, 8'h01, 3'h0, 1'b1, 1'b1, 16'h07D2, 16'h1941, 0, 0);
        chk(cmdOut.cmd, 16'h1941);
        $display("test command done");
    endtask : t_command
    task automatic t_claims();
        rd(8'h02, 3'h1, 16'h07D0, 1'b0, 16'h0000);
        acc(`MCF_TCP_PORT, 8'h03, 8'h01, 3'h2, 1'b0, 1'b0, 16'h07D0, 0, 0, 8'h04);
        acc(`MCF_TCP_PORT, 8'h03, 8'h02, 3'h2, 1'b0, 1'b0, 16'h07D0, 0, 0, 8'h04);
        $display("test claims done");
    endtask : t_claims
    task automatic t_fifo();
        mcf_resp_src_i.push(2'h1, 1);
        drain();
        rd(8'h01, 3'h0, 16'h03E8, 1'b0, 16'h0004);
        rd(8'h01, 3'h0, 16'h03E9, 1'b0, 16'h0006);
        rd(8'h01, 3'h0, 16'h03EB, 1'b0, 16'h0500);
        rd(8'h02, 3'h1, 16'h03E8, 1'b0, 16'h0004);
        rd(8'h01, 3'h0, 16'h03ED, 1'b1, 16'hA5A5);
        rd(8'h01, 3'h0, 16'h03E8, 1'b0, 16'h0000);
        rd(8'h02, 3'h1, 16'h03E8, 1'b0, 16'h0004);
        $display("test fifo done");
    endtask : t_fifo
    task automatic t_overflow();
        mcf_resp_src_i.push(2'h1, 32);
        drain();
        rd(8'h01, 3'h0, 16'h03E8, 1'b0, 16'h0064);
        rd(8'h02, 3'h1, 16'h03E8, 1'b0, 16'h0065);
        mcf_resp_src_i.push(2'h1, 1);
        drain();
        chk(16'(ingReady), 16'h0001);
        rd(8'h01, 3'h0, 16'h03E8, 1'b0, 16'h0065);
        rd(8'h01, 3'h0, 16'h03ED, 1'b1, 16'hA5A5);
        rd(8'h01, 3'h0, 16'h03E8, 1'b0, 16'h0065);
        wrw(16'h03E8, 16'h0001, 1'b0);
        rd(8'h01, 3'h0, 16'h03E8, 1'b0, 16'h0000);
        rd(8'h02, 3'h1, 16'h03E8, 1'b0, 16'h0000);
        $display("test overflow done");
    endtask : t_overflow

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        sys_rst = 1'b1;
        sessOpen = 1'b0;
        sessClose = 1'b0;
        sessId = 3'h0;
        reqValid = 1'b0;
        reqIn = '0;
        gotCmd = 1'b0;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        t_sessions();
        t_refusals();
        t_command();
        t_claims();
        t_fifo();
        t_overflow();
        summarize();
    end
endmodule : mcf_regmap_bench
